// ### inc/scc_map.svh
// Register offsets, field positions and reset values of the sense clock block
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

// Byte offsets on the Wishbone port
`define SCC_OFS_PERIOD 8'h00
`define SCC_OFS_DUTY 8'h04
`define SCC_OFS_CONVERSION_CONTROL 8'h08
`define SCC_OFS_START 8'h0c
`define SCC_OFS_RESULT 8'h10
`define SCC_OFS_ISTAT 8'h14
`define SCC_OFS_IMASK 8'h18

// Period control fields
`define SCC_PER_DIV 11:0
`define SCC_PER_SIZE 18:16
`define SCC_PER_SCALE 23:20
`define SCC_PER_SPREAD 24
`define SCC_PER_PRS 25

// High time fields
`define SCC_DUTY_WIDTH 11:0
`define SCC_DUTY_PWM 16

// Conversion control and start fields
`define SCC_ADC_TIME 7:0
`define SCC_ADC_MODE 17:16
`define SCC_START_BIT 0

// Result and interrupt fields
`define SCC_RES_CNT 15:0
`define SCC_RES_POL 16
`define SCC_IRQ_ADC 8

// Conversion mode codes
`define SCC_MODE_OFF 2'h0
`define SCC_MODE_REF 2'h1
`define SCC_MODE_HALF 2'h2
`define SCC_MODE_INPUT 2'h3

// Reset values
`define SCC_DIV_RST 12'h00f
`define SCC_WIDTH_RST 12'h008
`define SCC_TIME_RST 8'h0a
`define SCC_LFSR_SEED 12'h001

`endif

// ### inc/scc_pkg.sv
// Types shared by the sense clock block modules
package scc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_MEAS,
    ST_HALF,
    ST_CALIB
  } scc_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [11:0] div;
    logic [2:0] lsize;
    logic [3:0] lscale;
    logic spread;
    logic prs;
    logic [11:0] width;
    logic pwm;
    logic [7:0] stime;
    logic [1:0] mode;
    logic start;
    scc_state_t st;
    logic [15:0] cnt;
    logic [15:0] res;
    logic [15:0] gnd;
    logic pol;
    logic ent;
    logic cs1;
    logic cs2;
    logic ist;
    logic imask;
    logic irq;
    logic dac_en;
    logic dac_sink;
    logic reference_capacitor_gnd;
    logic reference_capacitor_smp;
    logic [12:0] scnt;
    logic [12:0] sper;
    logic sclk;
  } scc_top_st_t;

  typedef struct packed {
    logic [11:0] r;
  } scc_lfsr_st_t;

endpackage

// ### rtl/scc_lfsr.sv
// Selectable-length shift register for spreading the sense clock
`include "scc_map.svh"
module scc_lfsr
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic step,
  input wire logic [2:0] size,
  output logic [11:0] value,
  output logic msb
);

  // Maximal-length taps for lengths 5 to 12, one entry per size code
  localparam logic [11:0] TAPS [8] = '{12'h014, 12'h030, 12'h060, 12'h0b8,
                                      12'h110, 12'h240, 12'h500, 12'h829};
  localparam logic [11:0] LENM [8] = '{12'h01f, 12'h03f, 12'h07f, 12'h0ff,
                                      12'h1ff, 12'h3ff, 12'h7ff, 12'hfff};

  scc_lfsr_st_t s_q;
  scc_lfsr_st_t s_d;
  logic [11:0] cur;

  // An all-zero window would lock up, so it is reseeded at once
  always_comb begin
    cur = s_q.r & LENM[size];
    s_d = s_q;
    if (load || cur == 12'h000) begin
      s_d.r = `SCC_LFSR_SEED;
    end else if (step) begin
      s_d.r = {s_q.r[10:0], ^(s_q.r & TAPS[size])};
    end
    value = cur;
    msb = |(cur & ~(LENM[size] >> 1));
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{r: `SCC_LFSR_SEED};
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ### rtl/scc_top.sv
// Sense clock generator and slope-ADC calibration sequencer on Wishbone
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Half-reference and recovery states run only in half-reference count mode.
// - Half-reference state sinks current for half the ground-to-reference count.
// - Recovery state counts until comparator trips, raises interrupt, stores count.
// - Polarity reads 1 when input was below reference and DAC sourced.
// - Sample clock drives both the sense counter and the ADC counter.
// - Direct mode sense period is divider value plus one sample cycles.
// - Default duty is 50 percent for odd divider, longer high for even.
// - Width control sets high time; divider still sets the period.
// - Spread mode period is divider plus scaled shift register value plus one sample cycles.
// - Shift register length comes from a 3-bit period field.
// - Shift register value is scaled by the 4-bit scale field.
// - Width control works together with spread mode.
// - Pseudo-random select makes sense clock the shift register top bit.
// - Measure state counts until trip, sets interrupt bit 8, stores count.
// - Sampling grounds reference capacitor, or samples input in input mode.
// - Sequencer idles when mode is zero, on a start write of zero, after completion.
////////////////////////////////////////////////////////////////////////////////
`include "scc_map.svh"
module scc_top
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fast_comparator_i,
  output logic sense_clock_o,
  output logic current_dac_b_en_o,
  output logic current_dac_b_sink_o,
  output logic reference_capacitor_gnd_o,
  output logic reference_capacitor_sample_o,
  output logic irq_o
);

  scc_top_st_t s_q;
  scc_top_st_t s_d;
  logic hit;
  logic wr;
  logic trip;
  logic start_wr;
  logic [31:0] rd;
  logic [31:0] m;
  logic [31:0] v;
  logic [12:0] hi;
  logic lfsr_load;
  logic lfsr_step;
  logic [11:0] lfsr_val;
  logic lfsr_msb;

  ////////////////////////////////////////////////////////////////////////////
  // Spreading source

  scc_lfsr u_lfsr (
    .clk(clk),
    .rst_n(rst_n),
    .load(lfsr_load),
    .step(lfsr_step),
    .size(s_q.lsize),
    .value(lfsr_val),
    .msb(lfsr_msb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register read image, also the base for byte-lane merges on write
  always_comb begin
    rd = 32'h0000_0000;
    unique case (wb_adr_i)
      `SCC_OFS_PERIOD: begin
        rd[`SCC_PER_DIV] = s_q.div;
        rd[`SCC_PER_SIZE] = s_q.lsize;
        rd[`SCC_PER_SCALE] = s_q.lscale;
        rd[`SCC_PER_SPREAD] = s_q.spread;
        rd[`SCC_PER_PRS] = s_q.prs;
      end
      `SCC_OFS_DUTY: begin
        rd[`SCC_DUTY_WIDTH] = s_q.width;
        rd[`SCC_DUTY_PWM] = s_q.pwm;
      end
      `SCC_OFS_CONVERSION_CONTROL: begin
        rd[`SCC_ADC_TIME] = s_q.stime;
        rd[`SCC_ADC_MODE] = s_q.mode;
      end
      `SCC_OFS_START: rd[`SCC_START_BIT] = s_q.start;
      `SCC_OFS_RESULT: begin
        rd[`SCC_RES_CNT] = s_q.res;
        rd[`SCC_RES_POL] = s_q.pol;
      end
      `SCC_OFS_ISTAT: rd[`SCC_IRQ_ADC] = s_q.ist;
      `SCC_OFS_IMASK: rd[`SCC_IRQ_ADC] = s_q.imask;
      default: rd = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    hit = wb_cyc_i && wb_stb_i && !s_q.ack;
    wr = hit && wb_we_i;
    m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    v = (rd & ~m) | (wb_dat_i & m);
    start_wr = wr && wb_adr_i == `SCC_OFS_START && wb_sel_i[0];
    trip = s_q.cs2 != s_q.ent;
    lfsr_load = 1'b0;
    lfsr_step = 1'b0;
    s_d = s_q;

    // Comparator is asynchronous to clk: two flops before any use
    s_d.cs1 = fast_comparator_i;
    s_d.cs2 = s_q.cs1;

    // Bus slave: every access, mapped or not, gets one ack cycle
    s_d.ack = hit;
    if (hit) begin
      s_d.rdat = rd;
    end

    // Register writes
    if (wr) begin
      unique case (wb_adr_i)
        `SCC_OFS_PERIOD: begin
          s_d.div = v[`SCC_PER_DIV];
          s_d.lsize = v[`SCC_PER_SIZE];
          s_d.lscale = v[`SCC_PER_SCALE];
          s_d.spread = v[`SCC_PER_SPREAD];
          s_d.prs = v[`SCC_PER_PRS];
        end
        `SCC_OFS_DUTY: begin
          s_d.width = v[`SCC_DUTY_WIDTH];
          s_d.pwm = v[`SCC_DUTY_PWM];
        end
        `SCC_OFS_CONVERSION_CONTROL: begin
          s_d.stime = v[`SCC_ADC_TIME];
          s_d.mode = v[`SCC_ADC_MODE];
        end
        `SCC_OFS_START: s_d.start = v[`SCC_START_BIT];
        `SCC_OFS_ISTAT: begin
          if (v[`SCC_IRQ_ADC] && wb_sel_i[1]) begin
            s_d.ist = 1'b0;
          end
        end
        `SCC_OFS_IMASK: s_d.imask = v[`SCC_IRQ_ADC];
        default: s_d.ist = s_q.ist;
      endcase
    end

    // ADC sequencer; counts on clk, the sample clock
    unique case (s_q.st)
      ST_IDLE: s_d.cnt = 16'h0000;
      ST_SAMPLE: begin
        if (s_q.cnt[7:0] >= s_q.stime) begin
          s_d.st = ST_MEAS;
          s_d.cnt = 16'h0000;
          s_d.ent = s_q.cs2;
          // Input above reference means sink; reference modes always source
          s_d.dac_sink = (s_q.mode == `SCC_MODE_INPUT) && s_q.cs2;
          s_d.pol = !s_d.dac_sink;
        end else begin
          s_d.cnt = s_q.cnt + 16'h1;
        end
      end
      ST_MEAS: begin
        if (trip) begin
          s_d.res = s_q.cnt;
          s_d.ist = 1'b1;
          if (s_q.mode != `SCC_MODE_INPUT) begin
            s_d.gnd = s_q.cnt;
          end
          if (s_q.mode == `SCC_MODE_HALF) begin
            s_d.st = ST_HALF;
            s_d.cnt = {1'b0, s_q.cnt[15:1]};
            s_d.dac_sink = 1'b1;
          end else begin
            s_d.st = ST_IDLE;
          end
        end else if (s_q.cnt != 16'hffff) begin
          s_d.cnt = s_q.cnt + 16'h1;
        end
      end
      ST_HALF: begin
        // Loaded with half the count; leaves after that many cycles
        if (s_q.cnt <= 16'h1) begin
          s_d.st = ST_CALIB;
          s_d.cnt = 16'h0000;
          s_d.ent = s_q.cs2;
          s_d.dac_sink = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - 16'h1;
        end
      end
      ST_CALIB: begin
        if (trip) begin
          s_d.res = s_q.cnt;
          s_d.ist = 1'b1;
          s_d.st = ST_IDLE;
        end else if (s_q.cnt != 16'hffff) begin
          s_d.cnt = s_q.cnt + 16'h1;
        end
      end
    endcase

    // A start write always restarts or aborts; mode zero forces idle
    if (start_wr) begin
      s_d.cnt = 16'h0000;
      s_d.st = (v[`SCC_START_BIT] && s_d.mode != `SCC_MODE_OFF) ? ST_SAMPLE : ST_IDLE;
      lfsr_load = v[`SCC_START_BIT];
    end
    if (s_q.mode == `SCC_MODE_OFF) begin
      s_d.st = ST_IDLE;
    end

    // Analog controls follow the next state so they line up with it
    s_d.dac_en = s_d.st == ST_MEAS || s_d.st == ST_HALF || s_d.st == ST_CALIB;
    if (!s_d.dac_en) begin
      s_d.dac_sink = 1'b0;
    end
    s_d.reference_capacitor_gnd = s_d.st == ST_SAMPLE && s_d.mode != `SCC_MODE_INPUT;
    s_d.reference_capacitor_smp = s_d.st == ST_SAMPLE && s_d.mode == `SCC_MODE_INPUT;

    // Interrupt: status set above wins over a same-cycle clear
    s_d.irq = s_d.ist && s_d.imask;

    // Sense clock: high time from width field or from half the period
    hi = s_q.pwm ? {1'b0, s_q.width} : (s_q.sper >> 1) + 13'h1;
    s_d.sclk = s_q.prs ? lfsr_msb : (s_q.scnt < hi);
    if (s_q.scnt >= s_q.sper) begin
      s_d.scnt = 13'h0;
      if (s_q.spread) begin
        s_d.sper = {1'b0, s_q.div} + {1'b0, lfsr_val >> s_q.lscale};
        lfsr_step = 1'b1;
      end else begin
        s_d.sper = {1'b0, s_q.div};
      end
    end else begin
      s_d.scnt = s_q.scnt + 13'h1;
    end
    if (s_q.prs) begin
      lfsr_step = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.div <= `SCC_DIV_RST;
      s_q.sper <= {1'b0, `SCC_DIV_RST};
      s_q.width <= `SCC_WIDTH_RST;
      s_q.stime <= `SCC_TIME_RST;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign sense_clock_o = s_q.sclk;
  assign current_dac_b_en_o = s_q.dac_en;
  assign current_dac_b_sink_o = s_q.dac_sink;
  assign reference_capacitor_gnd_o = s_q.reference_capacitor_gnd;
  assign reference_capacitor_sample_o = s_q.reference_capacitor_smp;
  assign irq_o = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence meas_done;
    s_q.st == ST_MEAS && trip;
  endsequence

  sequence calib_done;
    s_q.st == ST_CALIB && trip;
  endsequence

  a_skip_half_states: assert property (
    meas_done ##0 (s_q.mode != `SCC_MODE_HALF) |=> s_q.st != ST_HALF)
    else $error("half state entered outside half mode");

  a_half_load: assert property (
    meas_done ##0 (s_q.mode == `SCC_MODE_HALF) && !start_wr
    |=> s_q.st == ST_HALF && s_q.cnt == (s_q.gnd >> 1) && s_q.gnd == $past(s_q.cnt))
    else $error("half count not derived from ground count");

  a_half_sinks: assert property (
    s_q.st == ST_HALF |-> current_dac_b_en_o && current_dac_b_sink_o)
    else $error("dac not sinking in half state");

  a_calib_result: assert property (
    calib_done ##0 !start_wr && s_q.mode != `SCC_MODE_OFF
    |=> s_q.ist && s_q.res == $past(s_q.cnt) && s_q.st == ST_IDLE)
    else $error("recovery count or interrupt wrong");

  a_pol_read: assert property (
    s_q.st == ST_MEAS |-> s_q.pol == !current_dac_b_sink_o)
    else $error("polarity disagrees with dac direction");

  a_period_wrap: assert property (
    s_q.scnt >= s_q.sper |=> s_q.scnt == 13'h0)
    else $error("sense counter did not wrap");

  a_direct_period: assert property (
    !s_q.spread && s_q.scnt >= s_q.sper |=> s_q.sper == {1'b0, $past(s_q.div)})
    else $error("direct period not from divider");

  a_prs_msb: assert property (
    s_q.prs |=> sense_clock_o == $past(lfsr_msb))
    else $error("sense clock not shift register top bit");

  a_meas_irq: assert property (
    meas_done ##0 !start_wr && s_q.mode != `SCC_MODE_OFF
    |=> s_q.ist && s_q.res == $past(s_q.cnt))
    else $error("measure end not flagged");

  a_sample_gnd: assert property (
    s_q.st == ST_SAMPLE |-> reference_capacitor_gnd_o == (s_q.mode != `SCC_MODE_INPUT)
    && reference_capacitor_sample_o == (s_q.mode == `SCC_MODE_INPUT))
    else $error("sampling switch wrong for mode");

  a_idle_mode: assert property (
    s_q.mode == `SCC_MODE_OFF |=> s_q.st == ST_IDLE)
    else $error("sequencer active with mode zero");

  a_irq_level: assert property (
    s_q.ist && s_q.imask |-> ##[0:1] irq_o)
    else $error("unmasked status did not raise interrupt");

endmodule

// ### dv/scc_cap_model.sv
// Behavioural reference capacitor, current DAC B and fast comparator
module scc_cap_model #(
  parameter int REF = 200,
  parameter int SINK = 2
) (
  input wire logic clk,
  input wire logic dac_en,
  input wire logic dac_sink,
  input wire logic cap_gnd,
  input wire logic cap_smp,
  input wire logic [15:0] vin,
  output logic comp
);
  timeunit 1ns;
  timeprecision 1ps;
  int v = 0;
  initial comp = 1'h0;
  // Voltage in DAC steps; sinking is faster than sourcing so a mismatch shows
  always @(posedge clk) begin
    if (cap_gnd) v <= 0;
    else if (cap_smp) v <= int'(vin);
    else if (dac_en) v <= dac_sink ? v - SINK : v + 1;
    comp <= v > REF;
  end
endmodule

// ### dv/sense_clock_and_adc_calibration_bench.sv
// Self-checking bench for the sense clock and slope-ADC calibration block
`include "scc_map.svh"
module sense_clock_and_adc_calibration_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REF = 200;
  localparam int SNK = 2;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rdat, dato;
  logic [15:0] vin = 0;
  logic comp, sclk, en, snk, cgnd, csmp, irq, ack;
  int failures = 0, samples_checked = 0;
  //////////////////////////////////////////////////
  scc_top uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .fast_comparator_i(comp), .sense_clock_o(sclk), .current_dac_b_en_o(en),
    .current_dac_b_sink_o(snk), .reference_capacitor_gnd_o(cgnd),
    .reference_capacitor_sample_o(csmp), .irq_o(irq));
  scc_cap_model #(.REF(REF), .SINK(SNK)) cap (.clk(clk), .dac_en(en), .dac_sink(snk),
    .cap_gnd(cgnd), .cap_smp(csmp), .vin(vin), .comp(comp));
  // Free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'h1) begin
      failures++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask
  // One classic cycle; the request is held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'h1 && ++n < 50);
    rdat = dato;
    cyc <= 1'h0;
    stb <= 1'h0;
    chk(n < 50, "bus answer");
  endtask
  // High time and period of one full sense clock cycle, in clk cycles
  task sense(output int hi, output int per);
    int n;
    for (n = 0; sclk !== 1'h0 && n < 9000; n++) @(posedge clk);
    for (n = n; sclk !== 1'h1 && n < 9000; n++) @(posedge clk);
    for (hi = 0; sclk === 1'h1 && hi < 9000; hi++) @(posedge clk);
    for (per = hi; sclk === 1'h0 && per < 9000; per++) @(posedge clk);
  endtask
  // Follows one conversion to its end, noting sink cycles and sampling kind
  task conv(output int s, output logic gs, output logic ss);
    int n;
    logic seen;
    s = 0;
    gs = 0;
    ss = 0;
    seen = 0;
    for (n = 0; n < 3000 && !(seen && en === 1'h0); n++) begin
      @(posedge clk);
      seen = seen | (en === 1'h1);
      s += (en === 1'h1 && snk === 1'h1);
      gs = gs | (cgnd === 1'h1);
      ss = ss | (csmp === 1'h1);
    end
    chk(n < 3000, "conversion end");
  endtask
  initial begin
    #1_000_000;
    failures++;
    stop_test;
  end
  //////////////////////////////////////////////////
  initial begin
    int hi, per, mn, mx, s, g, d, c, w;
    logic gs, ss;
    logic [61:0] q;
    void'($urandom(25));
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    wb(0, `SCC_OFS_PERIOD, 0);
    chk(rdat === 32'h0000_000f, "period reset");
    wb(0, `SCC_OFS_DUTY, 0);
    chk(rdat === 32'h0000_0008, "duty reset");
    wb(0, `SCC_OFS_CONVERSION_CONTROL, 0);
    chk(rdat === 32'h0000_000a, "control reset");
    wb(1, 8'h1c, 32'hffff_ffff);
    wb(0, 8'h1c, 0);
    chk(rdat === 32'h0000_0000, "unmapped read");
    sense(hi, per);
    chk(per == 16 && hi == 8, "reset clock");
    $display("test registers done");
    // Divider corners 1 and 2, then random dividers and widths
    for (int i = 0; i < 6; i++) begin
      d = (i < 2) ? i + 1 : $urandom_range(3, 60);
      w = $urandom_range(1, d);
      wb(1, `SCC_OFS_PERIOD, 32'(d));
      sense(hi, per);
      sense(hi, per);
      chk(per == d + 1, "direct period");
      chk(hi == d / 2 + 1, "direct high");
      wb(1, `SCC_OFS_DUTY, 32'h0001_0000 | 32'(w));
      sense(hi, per);
      sense(hi, per);
      chk(per == d + 1 && hi == w, "width period");
      wb(1, `SCC_OFS_DUTY, 32'(w));
    end
    $display("test direct clock done");
    d = 40;
    w = 12;
    wb(1, `SCC_OFS_DUTY, 32'h0001_000c);
    wb(1, `SCC_OFS_PERIOD, 32'h01f0_0028);
    sense(hi, per);
    sense(hi, per);
    chk(per == d + 1 && hi == w, "full scale down");
    // Long registers are scaled down so the run stays short and scaling is exercised
    for (int sz = 0; sz < 8; sz++) begin
      s = (sz > 3) ? sz - 3 : 0;
      wb(1, `SCC_OFS_PERIOD, 32'h0100_0028 | (32'(sz) << 16) | (32'(s) << 20));
      sense(hi, per);
      mn = 9999;
      mx = 0;
      repeat (6) begin
        sense(hi, per);
        mn = per < mn ? per : mn;
        mx = per > mx ? per : mx;
        chk(hi == w, "spread high");
      end
      c = d + 1 + (((1 << (sz + 5)) - 1) >> s);
      chk(mn >= d + 1 + (s == 0) && mx <= c, "spread range");
      chk(mx != mn, "spread varies");
    end
    wb(1, `SCC_OFS_PERIOD, 32'h0200_0028);
    // A 5-bit maximal sequence repeats every 31 cycles with 16 ones in it
    repeat (40) @(posedge clk);
    for (int k = 0; k < 62; k++) begin
      @(posedge clk);
      q[k] = sclk;
    end
    chk($countones(q[30:0]) == 16 && q[30:0] === q[61:31], "pseudo random sequence");
    // Runs of ones are at most 5 long and runs of zeros at most 4
    c = 0;
    repeat (300) begin
      sense(hi, per);
      c += (hi <= 5 && per - hi <= 4);
    end
    chk(c == 300, "pseudo random clock");
    wb(1, `SCC_OFS_PERIOD, 32'h0000_000f);
    wb(1, `SCC_OFS_DUTY, 32'h0000_0008);
    $display("test spread and random done");
    // Reference count, then the half-reference calibration
    wb(1, `SCC_OFS_IMASK, 32'h0000_0100);
    wb(1, `SCC_OFS_CONVERSION_CONTROL, 32'h0001_000a);
    wb(1, `SCC_OFS_START, 1);
    conv(s, gs, ss);
    wb(0, `SCC_OFS_RESULT, 0);
    g = rdat[15:0];
    chk(g >= REF && g <= REF + 8 && rdat[16] === 1'h1, "reference count");
    chk(s == 0 && gs && !ss, "no half state");
    chk(irq === 1'h1, "interrupt raised");
    wb(1, `SCC_OFS_ISTAT, 32'h0000_0100);
    @(posedge clk);
    chk(irq === 1'h0, "interrupt cleared");
    wb(1, `SCC_OFS_CONVERSION_CONTROL, 32'h0002_000a);
    wb(1, `SCC_OFS_START, 1);
    conv(s, gs, ss);
    wb(0, `SCC_OFS_RESULT, 0);
    c = rdat[15:0];
    chk(s == g / 2, "half discharge");
    chk(c + 8 >= SNK * (g / 2) && c <= SNK * (g / 2) + 8, "recovery count");
    chk(irq === 1'h1, "recovery interrupt");
    $display("test calibration done");
    // Input count on both sides of the reference, interrupt masked
    wb(1, `SCC_OFS_IMASK, 0);
    wb(1, `SCC_OFS_ISTAT, 32'h0000_0100);
    wb(1, `SCC_OFS_CONVERSION_CONTROL, 32'h0003_000a);
    for (int i = 0; i < 4; i++) begin
      vin <= i[0] ? 16'($urandom_range(220, 380)) : 16'($urandom_range(20, 180));
      wb(1, `SCC_OFS_START, 1);
      conv(s, gs, ss);
      wb(0, `SCC_OFS_RESULT, 0);
      d = vin > REF ? (vin - REF) / SNK : REF - vin;
      chk(rdat[16] === (vin < REF) && (s > 0) == (vin > REF), "polarity");
      chk(rdat[15:0] + 2 >= d && rdat[15:0] <= d + 8, "input count");
      chk(ss && !gs && irq === 1'h0, "input sampled");
    end
    $display("test input count done");
    wb(1, `SCC_OFS_CONVERSION_CONTROL, 32'h0000_000a);
    wb(1, `SCC_OFS_START, 1);
    c = 0;
    repeat (40) begin
      @(posedge clk);
      c += (en !== 1'h0);
    end
    chk(c == 0, "mode off idle");
    wb(1, `SCC_OFS_CONVERSION_CONTROL, 32'h0001_000a);
    wb(1, `SCC_OFS_START, 1);
    repeat (20) @(posedge clk);
    chk(en === 1'h1, "running");
    wb(1, `SCC_OFS_START, 0);
    repeat (2) @(posedge clk);
    c = 0;
    repeat (300) begin
      @(posedge clk);
      c += (en !== 1'h0);
    end
    chk(c == 0, "abort idle");
    $display("test idle and abort done");
    stop_test;
  end
endmodule
